// >>> design/flash_host.sv
// serial flash host controller: register slave and command sequencer
// Functional notes
// - code phase uses 1, 2 or 4 lanes
// - address and data lanes fixed per command
// - general register read: always eight dummy clocks
// - discovery read: always eight dummy clocks
// - protection writes need prior write enable
// - E8h: three address bytes, streamed data
// - E5h: three address bytes, one byte
// - E2h: four address bytes, streamed data
// - E3h: four address bytes, no data
// - E4h: code only, needs write enable
// - A7h read only in single-lane protocol
// - A6h: code only, needs write enable
// - B9h and ABh are code only
//
// Added by the designer: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module flash_host
    import flash_host_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic sel_n_o,
    output logic sclk_o,
    output logic [3:0] io_lanes_o,
    output logic [3:0] io_lanes_oe_o,
    input wire logic [3:0] io_lanes_i
);

    // ****************
    // state
    // ****************
    typedef struct packed {
        phase_t ph;
        logic [2:0] tick;
        logic hi;
        logic [5:0] clks;
        logic [3:0] dcnt;
        logic [31:0] sh;
        logic [31:0] rx;
        logic [7:0] op;
        logic [1:0] proto;
        logic [2:0] len;
        cmd_info_t info;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [31:0] rdata;
        logic wel;
        logic ref_wel;
        logic ref_op;
        logic sel_n;
        logic sclk;
        logic [3:0] io_out;
        logic [3:0] io_oe;
        logic waitreq;
        logic [31:0] readdata;
        logic [3:0] s1;
        logic [3:0] s2;
    } state_t;

    localparam state_t RST = '{ph: PH_IDLE, tick: 3'h0, hi: 1'b0, clks: 6'h0, dcnt: 4'h0,
        sh: 32'h0, rx: 32'h0, op: 8'h0, proto: 2'h0, len: 3'h0, info: '0,
        addr: 32'h0, wdata: 32'h0, rdata: 32'h0, wel: 1'b0, ref_wel: 1'b0,
        ref_op: 1'b0, sel_n: 1'b1, sclk: 1'b0, io_out: 4'h0, io_oe: 4'h0,
        waitreq: 1'b1, readdata: 32'h0, s1: 4'h0, s2: 4'h0};

    state_t st;
    state_t next_st;
    logic start_req;
    logic ci_needs_wel;

    // ****************
    // lane helpers
    // ****************
    function automatic logic [3:0] lane_mask(input logic [1:0] p);
        case (p)
            2'h0: return 4'h1;
            2'h1: return 4'h3;
            default: return 4'hF;
        endcase
    endfunction

    function automatic logic [3:0] lane_bits(input logic [31:0] s, input logic [1:0] p);
        case (p)
            2'h0: return {3'h0, s[31]};
            2'h1: return {2'h0, s[31:30]};
            default: return s[31:28];
        endcase
    endfunction

    function automatic logic [3:0] lane_in(input logic [3:0] s, input logic [1:0] p);
        case (p)
            2'h0: return {3'h0, s[1]};
            2'h1: return {2'h0, s[1:0]};
            default: return s;
        endcase
    endfunction

    // ****************
    // next state
    // ****************
    always_comb begin
        cmd_info_t ci;
        logic [2:0] rq;
        logic [31:0] sh_n;
        logic [31:0] rx_n;
        logic [5:0] w;
        ci = cmd_lookup(avs_writedata_i[CTRL_OP_LSB +: 8]);
        ci_needs_wel = ci.needs_wel;
        rq = avs_writedata_i[CTRL_LEN_LSB +: 3];
        sh_n = 32'h0;
        rx_n = 32'h0;
        next_st = st;
        next_st.s1 = io_lanes_i;
        next_st.s2 = st.s1;
        next_st.waitreq = 1'b1;
        w = 6'h1 << st.proto;
        start_req = avs_write_i && !st.waitreq && avs_address_i == REG_CTRL
            && avs_byteenable_i[0] && st.ph == PH_IDLE;

        // bus slave, answer one cycle after the request appears
        if ((avs_read_i || avs_write_i) && st.waitreq) begin
            next_st.waitreq = 1'b0;
            case (avs_address_i)
                REG_CTRL: next_st.readdata = {19'h0, st.len, st.proto, st.op};
                REG_ADDR: next_st.readdata = st.addr;
                REG_WDATA: next_st.readdata = st.wdata;
                REG_RDATA: next_st.readdata = st.rdata;
                REG_STATUS: next_st.readdata = {28'h0, st.ref_op, st.ref_wel, st.wel,
                    st.ph != PH_IDLE};
                default: next_st.readdata = 32'h0;
            endcase
        end
        if (avs_write_i && !st.waitreq) begin
            for (int b = 0; b < 4; b++) begin
                if (avs_byteenable_i[b] && avs_address_i == REG_ADDR) begin
                    next_st.addr[8*b +: 8] = avs_writedata_i[8*b +: 8];
                end
                if (avs_byteenable_i[b] && avs_address_i == REG_WDATA) begin
                    next_st.wdata[8*b +: 8] = avs_writedata_i[8*b +: 8];
                end
            end
        end

        // command launch
        if (start_req) begin
            next_st.op = avs_writedata_i[CTRL_OP_LSB +: 8];
            next_st.proto = avs_writedata_i[CTRL_PROTO_LSB +: 2];
            next_st.info = ci;
            next_st.ref_op = 1'b0;
            next_st.ref_wel = 1'b0;
            if (ci.dir == DIR_NONE) begin
                next_st.len = 3'h0;
            end else if (ci.one_byte || rq == 3'h0) begin
                next_st.len = 3'h1;
            end else if (rq > LEN_MAX) begin
                next_st.len = LEN_MAX;
            end else begin
                next_st.len = rq;
            end
            if (!ci.known || next_st.proto == PROTO_BAD
                    || (ci.ext_only && next_st.proto != PROTO_EXT)) begin
                next_st.ref_op = 1'b1;
            end else if (ci.needs_wel && !st.wel) begin
                next_st.ref_wel = 1'b1;
            end else begin
                next_st.ph = PH_CODE;
                next_st.sel_n = 1'b0;
                next_st.sh = {next_st.op, 24'h0};
                next_st.clks = 6'h8 >> next_st.proto;
                next_st.io_out = lane_bits(next_st.sh, next_st.proto);
                next_st.io_oe = lane_mask(next_st.proto);
                next_st.tick = 3'h0;
                next_st.hi = 1'b0;
                if (ci.needs_wel || next_st.op == OP_WRDI) begin
                    next_st.wel = 1'b0;
                end
            end
        end

        // bit engine, device samples on the rising edge
        if (st.ph == PH_GAP) begin
            if (st.tick == GAP_LAST) begin
                next_st.ph = PH_IDLE;
            end else begin
                next_st.tick = st.tick + 3'h1;
            end
        end else if (st.ph != PH_IDLE) begin
            if (st.tick != TICK_LAST) begin
                next_st.tick = st.tick + 3'h1;
            end else if (!st.hi) begin
                next_st.tick = 3'h0;
                next_st.hi = 1'b1;
                next_st.sclk = 1'b1;
                if (st.ph == PH_DUMMY) begin
                    next_st.dcnt = st.dcnt + 4'h1;
                end
            end else begin
                next_st.tick = 3'h0;
                next_st.hi = 1'b0;
                next_st.sclk = 1'b0;
                rx_n = (st.rx << w) | {28'h0, lane_in(st.s2, st.proto)};
                if (st.ph == PH_DATA && st.info.dir == DIR_IN) begin
                    next_st.rx = rx_n;
                end
                next_st.clks = st.clks - 6'h1;
                sh_n = st.sh << w;
                next_st.sh = sh_n;
                next_st.io_out = lane_bits(sh_n, st.proto);
                if (st.clks == 6'h1) begin
                    if (st.ph == PH_CODE && st.info.addr_bytes != 3'h0) begin
                        next_st.ph = PH_ADDR;
                        sh_n = (st.info.addr_bytes == ADDR_LONG) ? st.addr
                            : {st.addr[23:0], 8'h00};
                        next_st.sh = sh_n;
                        next_st.clks = {st.info.addr_bytes, 3'h0} >> st.proto;
                        next_st.io_out = lane_bits(sh_n, st.proto);
                    end else if ((st.ph == PH_CODE || st.ph == PH_ADDR)
                            && st.info.dummy != 4'h0) begin
                        next_st.ph = PH_DUMMY;
                        next_st.clks = {2'h0, st.info.dummy};
                        next_st.dcnt = 4'h0;
                        next_st.io_oe = 4'h0;
                    end else if (st.ph != PH_DATA && st.info.dir != DIR_NONE) begin
                        next_st.ph = PH_DATA;
                        next_st.clks = {st.len, 3'h0} >> st.proto;
                        next_st.rx = 32'h0;
                        next_st.sh = st.wdata;
                        next_st.io_out = lane_bits(st.wdata, st.proto);
                        next_st.io_oe = (st.info.dir == DIR_OUT) ? lane_mask(st.proto) : 4'h0;
                    end else begin
                        next_st.ph = PH_GAP;
                        next_st.sel_n = 1'b1;
                        next_st.io_oe = 4'h0;
                        if (st.op == OP_WREN) begin
                            next_st.wel = 1'b1;
                        end
                        if (st.ph == PH_DATA && st.info.dir == DIR_IN) begin
                            next_st.rdata = rx_n;
                        end
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= RST;
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    assign avs_readdata_o = st.readdata;
    assign avs_waitrequest_o = st.waitreq;
    assign sel_n_o = st.sel_n;
    assign sclk_o = st.sclk;
    assign io_lanes_o = st.io_out;
    assign io_lanes_oe_o = st.io_oe;

    // ****************
    // checks
    // ****************
    chk_code_lanes: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        st.ph == PH_CODE |-> st.io_oe == lane_mask(st.proto))
        else $error("code phase lane enables wrong");

    chk_write_lanes: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (st.ph == PH_DATA && st.info.dir == DIR_OUT) |-> st.io_oe == lane_mask(st.proto))
        else $error("write data lane enables wrong");

    chk_dummy_eight: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && st.ph == PH_DUMMY && next_st.ph != PH_DUMMY
            && (st.op == OP_RD_GPR || st.op == OP_RD_SFDP)) |-> st.dcnt == FIXED_DUMMY)
        else $error("fixed dummy count not eight");

    chk_wel_gate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && start_req && ci_needs_wel && !st.wel
            && avs_writedata_i[CTRL_PROTO_LSB +: 2] != PROTO_BAD)
        |=> (st.ph == PH_IDLE && st.ref_wel))
        else $error("command sent without write enable");

    chk_vlock_addr: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && st.ph == PH_CODE && next_st.ph == PH_ADDR
            && (st.op == OP_RD_VLOCK || st.op == OP_WR_VLOCK))
        |=> st.clks == (6'd24 >> st.proto))
        else $error("volatile lock address not three bytes");

    chk_nvlock_addr: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && st.ph == PH_CODE && next_st.ph == PH_ADDR
            && (st.op == OP_RD_NVLOCK || st.op == OP_WR_NVLOCK))
        |=> st.clks == (6'd32 >> st.proto))
        else $error("nonvolatile lock address not four bytes");

    chk_vlock_byte: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (st.ph == PH_DATA && st.op == OP_WR_VLOCK) |-> st.len == 3'h1)
        else $error("volatile lock write not one byte");

    chk_code_only: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && st.ph == PH_CODE && next_st.ph != PH_CODE
            && (st.op == OP_ER_NVLOCK || st.op == OP_WR_FREEZE
                || st.op == OP_DPD_ENTER || st.op == OP_DPD_EXIT))
        |=> (st.ph == PH_GAP && st.sel_n))
        else $error("code-only command grew extra phases");

    chk_freeze_ext: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && start_req && avs_writedata_i[7:0] == OP_RD_FREEZE
            && avs_writedata_i[CTRL_PROTO_LSB +: 2] != PROTO_EXT)
        |=> (st.ref_op && st.ph == PH_IDLE))
        else $error("freeze read allowed outside single lane");

    chk_wait_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && !st.waitreq) |=> st.waitreq)
        else $error("waitrequest low longer than one cycle");

    cov_vlock_read: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        st.ph == PH_DATA && st.op == OP_RD_VLOCK && next_st.ph == PH_GAP);
    cov_vlock_write: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        st.ph == PH_DATA && st.op == OP_WR_VLOCK && next_st.ph == PH_GAP);
    cov_wel_refused: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        st.ref_wel);
    cov_gpr_dummy: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        st.ph == PH_DUMMY && st.op == OP_RD_GPR);

endmodule // flash_host
`default_nettype wire

// >>> design/flash_host_pkg.sv
// constants, types and command table of the serial flash host controller
package flash_host_pkg;

    // ****************
    // timing
    // ****************
    localparam int CLK_NS = 50;
    localparam int SCK_HALF_NS = 200;
    localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam int GAP_NS = 200;
    localparam int GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [2:0] TICK_LAST = 3'(SCK_HALF_CYC - 1);
    localparam logic [2:0] GAP_LAST = 3'(GAP_CYC - 1);

    // ****************
    // operation codes
    // ****************
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_RD_VLOCK = 8'hE8;
    localparam logic [7:0] OP_WR_VLOCK = 8'hE5;
    localparam logic [7:0] OP_RD_NVLOCK = 8'hE2;
    localparam logic [7:0] OP_WR_NVLOCK = 8'hE3;
    localparam logic [7:0] OP_ER_NVLOCK = 8'hE4;
    localparam logic [7:0] OP_RD_FREEZE = 8'hA7;
    localparam logic [7:0] OP_WR_FREEZE = 8'hA6;
    localparam logic [7:0] OP_DPD_ENTER = 8'hB9;
    localparam logic [7:0] OP_DPD_EXIT = 8'hAB;
    localparam logic [7:0] OP_RD_GPR = 8'h96;
    localparam logic [7:0] OP_RD_SFDP = 8'h5A;

    // ****************
    // register map
    // ****************
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_ADDR = 5'h04;
    localparam logic [4:0] REG_WDATA = 5'h08;
    localparam logic [4:0] REG_RDATA = 5'h0C;
    localparam logic [4:0] REG_STATUS = 5'h10;
    localparam int CTRL_OP_LSB = 0;
    localparam int CTRL_PROTO_LSB = 8;
    localparam int CTRL_LEN_LSB = 10;
    localparam logic [2:0] LEN_MAX = 3'h4;
    localparam logic [1:0] PROTO_EXT = 2'h0;
    localparam logic [1:0] PROTO_BAD = 2'h3;
    localparam logic [3:0] FIXED_DUMMY = 4'h8;
    localparam logic [2:0] ADDR_SHORT = 3'h3;
    localparam logic [2:0] ADDR_LONG = 3'h4;

    typedef enum logic [1:0] {DIR_NONE = 2'h0, DIR_IN = 2'h1, DIR_OUT = 2'h2} dir_t;

    typedef enum logic [2:0] {
        PH_IDLE = 3'h0,
        PH_CODE = 3'h1,
        PH_ADDR = 3'h3,
        PH_DUMMY = 3'h2,
        PH_DATA = 3'h6,
        PH_GAP = 3'h7
    } phase_t;

    typedef struct packed {
        logic known;
        logic [2:0] addr_bytes;
        logic [3:0] dummy;
        dir_t dir;
        logic one_byte;
        logic needs_wel;
        logic ext_only;
    } cmd_info_t;

    function automatic cmd_info_t cmd_lookup(input logic [7:0] op);
        cmd_info_t c;
        c = '{known: 1'b1, addr_bytes: 3'h0, dummy: 4'h0, dir: DIR_NONE,
              one_byte: 1'b0, needs_wel: 1'b0, ext_only: 1'b0};
        case (op)
            OP_WREN, OP_WRDI, OP_DPD_ENTER, OP_DPD_EXIT: ;
            OP_RD_VLOCK: begin
                c.addr_bytes = ADDR_SHORT;
                c.dir = DIR_IN;
            end
            OP_WR_VLOCK: begin
                c.addr_bytes = ADDR_SHORT;
                c.dir = DIR_OUT;
                c.one_byte = 1'b1;
                c.needs_wel = 1'b1;
            end
            OP_RD_NVLOCK: begin
                c.addr_bytes = ADDR_LONG;
                c.dir = DIR_IN;
            end
            OP_WR_NVLOCK: begin
                c.addr_bytes = ADDR_LONG;
                c.needs_wel = 1'b1;
            end
            OP_ER_NVLOCK, OP_WR_FREEZE: c.needs_wel = 1'b1;
            OP_RD_FREEZE: begin
                c.dir = DIR_IN;
                c.ext_only = 1'b1;
            end
            OP_RD_GPR: begin
                c.dummy = FIXED_DUMMY;
                c.dir = DIR_IN;
            end
            OP_RD_SFDP: begin
                c.addr_bytes = ADDR_SHORT;
                c.dummy = FIXED_DUMMY;
                c.dir = DIR_IN;
            end
            default: c.known = 1'b0;
        endcase
        return c;
    endfunction

endpackage

// >>> testbench/flash_model.sv
// behavioural serial flash device facing the host controller
`timescale 1ns/10ps
`default_nettype none
module flash_model
    import flash_host_pkg::*;
#(
    parameter logic [7:0] GPR_BASE = 8'h40
) (
    input wire logic sel_n_i,
    input wire logic sclk_i,
    input wire logic [3:0] io_i,
    input wire logic [2:0] lanes_i,
    output logic [3:0] io_o,
    output logic [7:0] op_o,
    output logic [31:0] addr_o,
    output var int clocks_o,
    output var int sels_o,
    output logic dpd_o
);
    localparam int DEF_DUMMY = 0;
    int l, ab, dm, b;
    logic [63:0] sh;
    logic [7:0] vlock, nvlock, wb, v;
    logic freeze, wel, rd;

    function automatic logic [7:0] rbyte(input int i);
        case (op_o)
            OP_RD_GPR: return (i < 64) ? GPR_BASE + 8'(i) : 8'h00;
            OP_RD_SFDP: return addr_o[7:0] + 8'(i);
            OP_RD_VLOCK: return vlock;
            OP_RD_NVLOCK: return nvlock;
            default: return {7'h0, freeze};
        endcase
    endfunction

    initial begin
        {op_o, addr_o, sh, vlock, wb, v} = '0;
        {clocks_o, sels_o, ab, dm, b} = '0;
        {freeze, wel, rd, dpd_o} = 4'h0;
        io_o = 4'h0;
        nvlock = 8'hFF;
        l = 1;
    end

    // ****
    // shifting and decoding
    // ****
    always @(negedge sel_n_i) begin
        clocks_o = 0;
        sels_o++;
    end

    always @(posedge sclk_i) begin
        if (!sel_n_i) begin
            l = int'(lanes_i);
            for (int k = l - 1; k >= 0; k--) begin
                sh = {sh[62:0], (l == 1) ? io_i[0] : io_i[k]};
            end
            clocks_o++;
            if (clocks_o == 8 / l) begin
                op_o = sh[7:0];
                ab = (op_o inside {OP_RD_VLOCK, OP_WR_VLOCK, OP_RD_SFDP}) ? 3 : 0;
                if (op_o inside {OP_RD_NVLOCK, OP_WR_NVLOCK}) ab = 4;
                dm = (op_o inside {OP_RD_GPR, OP_RD_SFDP}) ? 8 : DEF_DUMMY;
                rd = op_o inside {OP_RD_VLOCK, OP_RD_NVLOCK, OP_RD_FREEZE, OP_RD_GPR, OP_RD_SFDP};
            end
            if (ab > 0 && clocks_o == (8 + ab * 8) / l) addr_o = (ab == 3) ? {8'h0, sh[23:0]} : sh[31:0];
            wb = sh[7:0];
        end
    end

    always @(negedge sclk_i) begin
        if (!sel_n_i && rd && clocks_o >= (8 + ab * 8) / l + dm) begin
            b = (clocks_o - (8 + ab * 8) / l - dm) * l;
            v = rbyte(b / 8);
            for (int j = 0; j < l; j++) begin
                io_o[(l == 1) ? 1 : j] = v[7 - (b % 8) - (l - 1 - j)];
            end
        end
    end

    // ****
    // execution at select release
    // ****
    always @(posedge sel_n_i) begin
        io_o = ~io_o;
        if (clocks_o == ((op_o == OP_WR_VLOCK) ? 40 : 8 + ab * 8) / l
            && (!dpd_o || op_o == OP_DPD_EXIT)) begin
            case (op_o)
                OP_WREN: wel = 1'b1;
                OP_WRDI: wel = 1'b0;
                OP_DPD_ENTER: dpd_o = 1'b1;
                OP_DPD_EXIT: dpd_o = 1'b0;
                OP_WR_VLOCK: {vlock, wel} = {wel ? wb : vlock, 1'b0};
                OP_WR_NVLOCK: {nvlock, wel} = {wel ? 8'h00 : nvlock, 1'b0};
                OP_ER_NVLOCK: {nvlock, wel} = {wel ? 8'hFF : nvlock, 1'b0};
                OP_WR_FREEZE: {freeze, wel} = {freeze | wel, 1'b0};
                default: ;
            endcase
        end
    end
endmodule // flash_model
`default_nettype wire

// >>> testbench/test_flash_host.sv
// self-checking bench of the serial flash host controller
`timescale 1ns/10ps
`default_nettype none
module test_flash_host
    import flash_host_pkg::*;
;
    logic clk_i, rst_n_i, ce_i, avs_read_i, avs_write_i, avs_waitrequest_o, sel_n, sclk, mdl_dpd;
    logic [4:0] avs_address_i;
    logic [31:0] avs_writedata_i, avs_readdata_o, mdl_addr, q, st;
    logic [3:0] avs_byteenable_i, io_out, io_oe, io_in, mdl_io;
    logic [2:0] lanes;
    logic [7:0] mdl_op;
    int mdl_clk, mdl_sels, fail_count, num_checks, s0, ln;

    assign io_in = (io_oe & io_out) | (~io_oe & mdl_io);

    flash_host dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .sel_n_o(sel_n), .sclk_o(sclk), .io_lanes_o(io_out), .io_lanes_oe_o(io_oe),
        .io_lanes_i(io_in));
    flash_model mdl_u (.sel_n_i(sel_n), .sclk_i(sclk), .io_i(io_in), .lanes_i(lanes),
        .io_o(mdl_io), .op_o(mdl_op), .addr_o(mdl_addr), .clocks_o(mdl_clk),
        .sels_o(mdl_sels), .dpd_o(mdl_dpd));

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    // ****
    // tasks
    // ****
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        int n;
        @(posedge clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= wr;
        avs_read_i <= ~wr;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 100);
        if (avs_waitrequest_o !== 1'b0) begin
            fail_count++;
            $display("BAD waitrequest expected 0 seen stuck");
            finish_test();
        end
        r = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask

    task automatic run(input logic [7:0] op, input logic [1:0] pr, input logic [2:0] n);
        int k;
        ln = (pr == 2'h0) ? 1 : (pr == 2'h1) ? 2 : 4;
        lanes <= 3'(ln);
        bus(1'b1, REG_CTRL, {19'h0, n, pr, op}, q);
        k = 0;
        st = 32'h1;
        while (st[0] !== 1'b0 && k < 400) begin
            bus(1'b0, REG_STATUS, 32'h0, st);
            k++;
        end
        check("busy_end", {31'h0, st[0]}, 32'h0);
        if (st[0] !== 1'b0) begin
            finish_test();
        end
        bus(1'b0, REG_RDATA, 32'h0, q);
    endtask

    function automatic int ecl(input int ab, input int dm, input int nd);
        return (8 + ab * 8 + nd * 8) / ln + dm;
    endfunction

    // ****
    // tests
    // ****
    initial begin
        {rst_n_i, avs_read_i, avs_write_i, avs_address_i, avs_writedata_i} = '0;
        {fail_count, num_checks, s0, ln} = '0;
        ce_i = 1'b1;
        avs_byteenable_i = 4'hF;
        lanes = 3'h1;
        repeat (12) @(posedge clk_i);
        check("reset_sel", {27'h0, sel_n, io_oe}, 32'h10);
        rst_n_i <= 1'b1;
        for (int p = 0; p < 3; p++) begin
            run(OP_DPD_ENTER, 2'(p), 3'h0);
            check("dpd_op", {24'h0, mdl_op}, {24'h0, OP_DPD_ENTER});
            check("dpd_clocks", mdl_clk, ecl(0, 0, 0));
            check("dpd_on", {31'h0, mdl_dpd}, 32'h1);
            run(OP_DPD_EXIT, 2'(p), 3'h0);
            check("dpd_off", {31'h0, mdl_dpd}, 32'h0);
        end
        $display("test code_only done");
        s0 = mdl_sels;
        run(OP_WR_FREEZE, PROTO_EXT, 3'h0);
        check("freeze_refused", st & 32'hC, 32'h4);
        check("freeze_nosel", mdl_sels, s0);
        run(OP_WREN, 2'h2, 3'h0);
        check("wel_flag", st & 32'hE, 32'h2);
        run(OP_WR_FREEZE, 2'h2, 3'h0);
        check("freeze_clocks", mdl_clk, ecl(0, 0, 0));
        run(OP_RD_FREEZE, PROTO_EXT, 3'h1);
        check("freeze_read", q & 32'hFF, 32'h1);
        check("freeze_rclocks", mdl_clk, ecl(0, 0, 1));
        run(OP_RD_FREEZE, 2'h1, 3'h1);
        check("freeze_dual", st & 32'hC, 32'h8);
        $display("test freeze done");
        bus(1'b1, REG_ADDR, 32'h0012_3456, q);
        bus(1'b1, REG_WDATA, 32'h5A00_0000, q);
        run(OP_WREN, 2'h2, 3'h0);
        run(OP_WR_VLOCK, 2'h2, 3'h0);
        check("vlock_addr", mdl_addr, 32'h0012_3456);
        check("vlock_clocks", mdl_clk, ecl(3, 0, 1));
        run(OP_RD_VLOCK, 2'h1, 3'h2);
        check("vlock_read", q & 32'hFFFF, 32'h5A5A);
        check("vlock_rclocks", mdl_clk, ecl(3, 0, 2));
        bus(1'b1, REG_ADDR, 32'hA1B2_C3D4, q);
        run(OP_WREN, PROTO_EXT, 3'h0);
        run(OP_WR_NVLOCK, PROTO_EXT, 3'h0);
        check("nvlock_addr", mdl_addr, 32'hA1B2_C3D4);
        check("nvlock_clocks", mdl_clk, ecl(4, 0, 0));
        run(OP_RD_NVLOCK, 2'h2, 3'h1);
        check("nvlock_read", q & 32'hFF, 32'h00);
        check("nvlock_rclocks", mdl_clk, ecl(4, 0, 1));
        run(OP_ER_NVLOCK, PROTO_EXT, 3'h0);
        check("erase_refused", st & 32'hC, 32'h4);
        run(OP_WREN, 2'h1, 3'h0);
        run(OP_ER_NVLOCK, 2'h1, 3'h0);
        check("erase_clocks", mdl_clk, ecl(0, 0, 0));
        run(OP_RD_NVLOCK, PROTO_EXT, 3'h1);
        check("erase_read", q & 32'hFF, 32'hFF);
        $display("test lock_bits done");
        run(OP_RD_GPR, PROTO_EXT, 3'h4);
        check("gpr_read", q, 32'h4041_4243);
        check("gpr_clocks", mdl_clk, ecl(0, 8, 4));
        avs_byteenable_i <= 4'h1;
        bus(1'b1, REG_ADDR, 32'hFFFF_FF10, q);
        avs_byteenable_i <= 4'hF;
        run(OP_RD_SFDP, 2'h2, 3'h4);
        check("sfdp_addr", mdl_addr, 32'h00B2_C310);
        check("sfdp_read", q, 32'h1011_1213);
        check("sfdp_clocks", mdl_clk, ecl(3, 8, 4));
        $display("test fixed_dummy done");
        run(8'h00, PROTO_EXT, 3'h0);
        check("unknown_op", st & 32'hC, 32'h8);
        bus(1'b1, REG_CTRL, {19'h0, 3'h0, PROTO_EXT, OP_WRDI}, q);
        ce_i <= 1'b0;
        repeat (40) @(posedge clk_i);
        check("ce_sel", {31'h0, sel_n}, 32'h0);
        check("ce_frozen", mdl_clk, 32'h0);
        ce_i <= 1'b1;
        run(OP_WRDI, PROTO_EXT, 3'h0);
        check("busy_ignored", mdl_clk, 32'h8);
        check("wrdi_wel", st & 32'h2, 32'h0);
        run(OP_DPD_ENTER, PROTO_BAD, 3'h0);
        check("bad_proto", st & 32'hC, 32'h8);
        bus(1'b0, 5'h14, 32'h0, q);
        check("unmapped", q, 32'h0);
        $display("test refusals done");
        finish_test();
    end
endmodule // test_flash_host
`default_nettype wire
